/* src/i2m_master.sv */
/*
  I2C master sequencer: start, repeated start, stop and byte transmit
  with acknowledge capture, paced by a reloadable baud counter.
  Assumes open-drain SCL/SDA resolved outside and a plain register port.
*/
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "i2m_params.svh"

// How it works
// - Busy buffer write sets collision, keeps buffer
// - Control request writes ignored until start completes
// - Start with lines high loads baud counter
// - Expiry with lines high drives SDA low
// - Reload, then clear start, halt, hold SDA
// - Lines low or early SCL low aborts start
// - Restart request ignored while sequencer busy
// - Restart pulls SCL low, releases SDA, then SCL
// - SCL high: both high one period, SDA low
// - Restart ends: SCL low, request cleared, no reload
// - Start seen sets status; event after expiry
// - Restart collision on SDA low or SCL fall
// - Idle buffer write sets full, starts sending
// - SDA changes after SCL falls; one period each
// - Byte shifted out most significant bit first
// - Eighth falling edge clears full, releases SDA
// - Ninth clock SDA captured into ack status
// - After ninth clock: event, halt, SCL held low
// - Stop or restart completion raises event
// - Released SCL pauses counter until sampled high
module i2m_master #(
  parameter int BRG_W = 8
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  // Bus lines
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe
);

  // ************************************************************
  // Declarations
  // ************************************************************
  i2m_pkg::i2m_state_e state_ff;
  i2m_pkg::i2m_state_e nxt_state;
  logic [7:0]       xfer_buffer_ff;
  logic [7:0]       shift_reg_ff;
  logic [7:0]       nxt_shift;
  logic [3:0]       bit_cnt_ff;
  logic [3:0]       nxt_bits;
  logic [2:0]       req_ff;
  logic [2:0]       req_clr;
  logic [BRG_W-1:0] baud_reload_value_ff;
  logic [BRG_W-1:0] brg_cnt_ff;
  logic             brg_run_ff;
  logic             brg_exp;
  logic             brg_load;
  logic             brg_halt;
  logic [2:0]       flags_ff;
  logic             buffer_full_ff;
  logic             start_seen_ff;
  logic             stop_seen_ff;
  logic             ack_received_status_ff;
  logic             scl_low_ff;
  logic             sda_low_ff;
  logic             nxt_scl_low;
  logic             nxt_sda_low;
  logic             scl_q;
  logic             sda_q;
  logic             busy;
  logic             buf_wr;
  logic             buf_wr_ok;
  logic             ctl_wr_ok;
  logic             abort;
  logic             ev_set;
  logic             bcl_set;
  logic             s_set;
  logic             p_set;
  logic             ack_cap;
  logic             bf_clr;

  // ************************************************************
  // Line sampling
  // ************************************************************
  i2m_sync u_scl_sync (
    .clk     (clk),
    .rst     (rst),
    .line_i  (scl_i),
    .level_q (scl_q)
  );

  i2m_sync u_sda_sync (
    .clk     (clk),
    .rst     (rst),
    .line_i  (sda_i),
    .level_q (sda_q)
  );

  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_low_ff;
  assign sda_oe = sda_low_ff;

  // ************************************************************
  // Register port decode
  // ************************************************************
  assign busy      = (state_ff != i2m_pkg::S_IDLE) || (|req_ff);
  assign buf_wr    = wr_en && (addr == `I2M_OFS_BUF);
  assign buf_wr_ok = buf_wr && !busy;
  assign ctl_wr_ok = wr_en && (addr == `I2M_OFS_CTL) && !busy;

  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_buffer_ff <= 8'h00;
    end else if (buf_wr_ok) begin
      xfer_buffer_ff <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      baud_reload_value_ff <= BRG_W'(`I2M_BAUD_RST);
    end else if (wr_en && addr == `I2M_OFS_BAUD) begin
      baud_reload_value_ff <= BRG_W'(wdata);
    end
  end

  // Requests: hardware clears, software writes locked while busy
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ff <= 3'h0;
    end else begin
      req_ff <= (req_ff & ~req_clr) | (ctl_wr_ok ? wdata[2:0] : 3'h0);
    end
  end

  // Sticky flags, write one to clear, a same-cycle set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= 3'h0;
    end else begin
      flags_ff <= (flags_ff & ~((wr_en && addr == `I2M_OFS_FLAG) ? wdata[2:0] : 3'h0))
                | {buf_wr && busy, bcl_set, ev_set};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `I2M_OFS_BUF:  rdata <= xfer_buffer_ff;
        `I2M_OFS_CTL:  rdata <= {1'b0, ack_received_status_ff, 3'h0, req_ff};
        `I2M_OFS_BAUD: rdata <= 8'(baud_reload_value_ff);
        `I2M_OFS_STAT: rdata <= {4'h0, busy, stop_seen_ff, start_seen_ff, buffer_full_ff};
        `I2M_OFS_FLAG: rdata <= {5'h00, flags_ff};
        default:       rdata <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Baud counter
  // ************************************************************
  assign brg_exp = brg_run_ff && (brg_cnt_ff == '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      brg_cnt_ff <= '0;
      brg_run_ff <= 1'b0;
    end else if (brg_load) begin
      brg_cnt_ff <= baud_reload_value_ff;
      brg_run_ff <= 1'b1;
    end else if (brg_halt) begin
      brg_run_ff <= 1'b0;
    end else if (brg_run_ff && brg_cnt_ff != '0) begin
      brg_cnt_ff <= brg_cnt_ff - 1'b1;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    nxt_state   = state_ff;
    nxt_shift   = shift_reg_ff;
    nxt_bits    = bit_cnt_ff;
    nxt_scl_low = scl_low_ff;
    nxt_sda_low = sda_low_ff;
    req_clr     = 3'h0;
    brg_load    = 1'b0;
    brg_halt    = 1'b0;
    ev_set      = 1'b0;
    bcl_set     = 1'b0;
    s_set       = 1'b0;
    p_set       = 1'b0;
    ack_cap     = 1'b0;
    bf_clr      = 1'b0;
    abort       = 1'b0;
    case (state_ff)
      i2m_pkg::S_IDLE: begin
        if (req_ff[`I2M_REQ_START]) begin
          if (scl_q && sda_q) begin
            brg_load  = 1'b1;
            nxt_state = i2m_pkg::S_ST_WAIT;
          end else if (!scl_q && !sda_q) begin
            abort = 1'b1;
          end
        end else if (req_ff[`I2M_REQ_RESTART]) begin
          nxt_scl_low = 1'b1;
          nxt_sda_low = 1'b0;
          nxt_state   = i2m_pkg::S_RS_LOW;
        end else if (req_ff[`I2M_REQ_STOP]) begin
          nxt_scl_low = 1'b1;
          nxt_sda_low = 1'b1;
          nxt_state   = i2m_pkg::S_SP_LOW;
        end else if (buf_wr_ok) begin
          nxt_shift   = wdata;
          nxt_bits    = 4'h0;
          nxt_scl_low = 1'b1;
          nxt_state   = i2m_pkg::S_TX_LOW;
        end
      end
      i2m_pkg::S_ST_WAIT: begin
        if (!scl_q) begin
          abort = 1'b1;
        end else if (brg_exp) begin
          if (sda_q) begin
            nxt_sda_low = 1'b1;
            s_set       = 1'b1;
            brg_load    = 1'b1;
            nxt_state   = i2m_pkg::S_ST_HOLD;
          end else begin
            abort = 1'b1;
          end
        end
      end
      i2m_pkg::S_ST_HOLD: begin
        if (brg_exp) begin
          req_clr[`I2M_REQ_START] = 1'b1;
          brg_halt  = 1'b1;
          ev_set    = 1'b1;
          nxt_state = i2m_pkg::S_IDLE;
        end
      end
      i2m_pkg::S_RS_LOW: begin
        if (!brg_run_ff && !scl_q) begin
          brg_load = 1'b1;
        end else if (brg_exp) begin
          if (sda_q) begin
            nxt_scl_low = 1'b0;
            brg_halt    = 1'b1;
            nxt_state   = i2m_pkg::S_RS_SCLH;
          end else begin
            abort = 1'b1;
          end
        end
      end
      i2m_pkg::S_RS_SCLH: begin
        if (!brg_run_ff) begin
          if (scl_q && sda_q) begin
            brg_load = 1'b1;
          end else if (scl_q) begin
            abort = 1'b1;
          end
        end else if (!scl_q || !sda_q) begin
          abort = 1'b1;
        end else if (brg_exp) begin
          nxt_sda_low = 1'b1;
          s_set       = 1'b1;
          brg_load    = 1'b1;
          nxt_state   = i2m_pkg::S_RS_SDAL;
        end
      end
      i2m_pkg::S_RS_SDAL: begin
        if (brg_exp) begin
          nxt_scl_low = 1'b1;
          req_clr[`I2M_REQ_RESTART] = 1'b1;
          brg_halt    = 1'b1;
          ev_set      = 1'b1;
          nxt_state   = i2m_pkg::S_IDLE;
        end
      end
      i2m_pkg::S_TX_LOW: begin
        if (!brg_run_ff && !scl_q) begin
          brg_load = 1'b1;
          if (bit_cnt_ff == `I2M_ACK_BIT) begin
            nxt_sda_low = 1'b0;
            bf_clr      = 1'b1;
          end else begin
            nxt_sda_low = ~shift_reg_ff[7];
          end
        end else if (brg_exp) begin
          nxt_scl_low = 1'b0;
          brg_halt    = 1'b1;
          nxt_state   = i2m_pkg::S_TX_HIGH;
        end
      end
      i2m_pkg::S_TX_HIGH: begin
        if (!brg_run_ff && scl_q) begin
          brg_load = 1'b1;
        end else if (brg_run_ff && !sda_low_ff && !sda_q
                     && bit_cnt_ff != `I2M_ACK_BIT) begin
          abort = 1'b1;
        end else if (brg_exp) begin
          nxt_scl_low = 1'b1;
          brg_halt    = 1'b1;
          if (bit_cnt_ff == `I2M_ACK_BIT) begin
            ack_cap   = 1'b1;
            ev_set    = 1'b1;
            nxt_state = i2m_pkg::S_IDLE;
          end else begin
            nxt_shift = {shift_reg_ff[6:0], 1'b0};
            nxt_bits  = bit_cnt_ff + 4'h1;
            nxt_state = i2m_pkg::S_TX_LOW;
          end
        end
      end
      i2m_pkg::S_SP_LOW: begin
        if (!brg_run_ff && !sda_q && !scl_q) begin
          brg_load = 1'b1;
        end else if (brg_exp) begin
          nxt_scl_low = 1'b0;
          brg_halt    = 1'b1;
          nxt_state   = i2m_pkg::S_SP_HIGH;
        end
      end
      i2m_pkg::S_SP_HIGH: begin
        if (!brg_run_ff && scl_q) begin
          brg_load = 1'b1;
        end else if (brg_exp) begin
          nxt_sda_low = 1'b0;
          brg_halt    = 1'b1;
          nxt_state   = i2m_pkg::S_SP_REL;
        end
      end
      i2m_pkg::S_SP_REL: begin
        if (!brg_run_ff && scl_q && sda_q) begin
          brg_load = 1'b1;
          p_set    = 1'b1;
        end else if (brg_exp) begin
          req_clr[`I2M_REQ_STOP] = 1'b1;
          brg_halt  = 1'b1;
          ev_set    = 1'b1;
          nxt_state = i2m_pkg::S_IDLE;
        end
      end
      default: begin
        nxt_state = i2m_pkg::S_IDLE;
      end
    endcase
    if (abort) begin
      bcl_set     = 1'b1;
      req_clr     = 3'h7;
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      brg_load    = 1'b0;
      brg_halt    = 1'b1;
      bf_clr      = 1'b1;
      nxt_state   = i2m_pkg::S_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff     <= i2m_pkg::S_IDLE;
      shift_reg_ff <= 8'h00;
      bit_cnt_ff   <= 4'h0;
      scl_low_ff   <= 1'b0;
      sda_low_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      shift_reg_ff <= nxt_shift;
      bit_cnt_ff   <= nxt_bits;
      scl_low_ff   <= nxt_scl_low;
      sda_low_ff   <= nxt_sda_low;
    end
  end

  // ************************************************************
  // Status bits
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      buffer_full_ff <= 1'b0;
    end else if (buf_wr_ok) begin
      buffer_full_ff <= 1'b1;
    end else if (bf_clr) begin
      buffer_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_seen_ff <= 1'b0;
      stop_seen_ff  <= 1'b0;
    end else if (s_set) begin
      start_seen_ff <= 1'b1;
      stop_seen_ff  <= 1'b0;
    end else if (p_set) begin
      start_seen_ff <= 1'b0;
      stop_seen_ff  <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_received_status_ff <= 1'b0;
    end else if (ack_cap) begin
      ack_received_status_ff <= sda_q;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_tx_ack_end;
    state_ff == i2m_pkg::S_TX_HIGH && brg_exp && bit_cnt_ff == `I2M_ACK_BIT;
  endsequence

  sequence s_rs_end;
    state_ff == i2m_pkg::S_RS_SDAL && brg_exp;
  endsequence

  property p_write_collision_flag;
    @(posedge clk) disable iff (rst)
    (buf_wr && busy) |=> flags_ff[`I2M_FLG_WRITE_COLLISION_FLAG] && $stable(xfer_buffer_ff);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("busy buffer write not refused");

  property p_ctl_lock;
    @(posedge clk) disable iff (rst)
    (wr_en && addr == `I2M_OFS_CTL && state_ff != i2m_pkg::S_IDLE
     && wdata[`I2M_REQ_RESTART] && !req_ff[`I2M_REQ_RESTART]) |=> !req_ff[`I2M_REQ_RESTART];
  endproperty
  a_ctl_lock: assert property (p_ctl_lock) else $error("request taken while busy");

  property p_start_load;
    @(posedge clk) disable iff (rst)
    (state_ff == i2m_pkg::S_IDLE && req_ff[`I2M_REQ_START] && scl_q && sda_q)
    |=> brg_run_ff && brg_cnt_ff == $past(baud_reload_value_ff);
  endproperty
  a_start_load: assert property (p_start_load) else $error("start did not load counter");

  property p_start_sda;
    @(posedge clk) disable iff (rst)
    (state_ff == i2m_pkg::S_ST_WAIT && brg_exp && scl_q && sda_q)
    |=> sda_oe && !scl_oe && start_seen_ff ##1 brg_run_ff;
  endproperty
  a_start_sda: assert property (p_start_sda) else $error("start edge missing");

  property p_start_bcl;
    @(posedge clk) disable iff (rst)
    (state_ff == i2m_pkg::S_ST_WAIT && !scl_q)
    |=> flags_ff[`I2M_FLG_BCL] && state_ff == i2m_pkg::S_IDLE && !req_ff[`I2M_REQ_START];
  endproperty
  a_start_bcl: assert property (p_start_bcl) else $error("start collision not flagged");

  property p_rs_end;
    @(posedge clk) disable iff (rst)
    s_rs_end |=> scl_oe && sda_oe && !req_ff[`I2M_REQ_RESTART]
                 && flags_ff[`I2M_FLG_EVENT] && !brg_run_ff;
  endproperty
  a_rs_end: assert property (p_rs_end) else $error("restart end wrong");

  property p_ack;
    @(posedge clk) disable iff (rst)
    s_tx_ack_end |=> ack_received_status_ff == $past(sda_q) && scl_oe
                     && !brg_run_ff && flags_ff[`I2M_FLG_EVENT];
  endproperty
  a_ack: assert property (p_ack) else $error("ack capture or event wrong");

  property p_stretch;
    @(posedge clk) disable iff (rst)
    (state_ff == i2m_pkg::S_TX_HIGH && !scl_q && !brg_run_ff) |=> !brg_run_ff;
  endproperty
  a_stretch: assert property (p_stretch) else $error("counter ran with SCL low");

  property p_sticky;
    @(posedge clk) disable iff (rst)
    (flags_ff[`I2M_FLG_BCL] && !(wr_en && addr == `I2M_OFS_FLAG))
    |=> flags_ff[`I2M_FLG_BCL];
  endproperty
  a_sticky: assert property (p_sticky) else $error("collision flag lost");

endmodule : i2m_master

/* src/i2m_params.svh */
/*
  Offsets, field positions and reset values of the I2C master sequencer.
  Assumes an 8-bit register port with byte offsets on word boundaries.
*/
`ifndef I2M_PARAMS_SVH
`define I2M_PARAMS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define I2M_OFS_BUF   8'h00
`define I2M_OFS_CTL   8'h04
`define I2M_OFS_BAUD  8'h08
`define I2M_OFS_STAT  8'h0C
`define I2M_OFS_FLAG  8'h10

// ************************************************************
// Field positions
// ************************************************************
`define I2M_REQ_START    0
`define I2M_REQ_RESTART  1
`define I2M_REQ_STOP     2
`define I2M_CTL_ACK      6
`define I2M_STAT_BF      0
`define I2M_STAT_S       1
`define I2M_STAT_P       2
`define I2M_STAT_BUSY    3
`define I2M_FLG_EVENT    0
`define I2M_FLG_BCL      1
`define I2M_FLG_WRITE_COLLISION_FLAG     2

// ************************************************************
// Reset values and counts
// ************************************************************
`define I2M_BAUD_RST  8'h09
`define I2M_ACK_BIT   4'h8

`endif

/* src/i2m_pkg.sv */
/*
  Types of the I2C master sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package i2m_pkg;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [11:0] {
    S_IDLE    = 12'h001,
    S_ST_WAIT = 12'h002,
    S_ST_HOLD = 12'h004,
    S_RS_LOW  = 12'h008,
    S_RS_SCLH = 12'h010,
    S_RS_SDAL = 12'h020,
    S_TX_LOW  = 12'h040,
    S_TX_HIGH = 12'h080,
    S_SP_LOW  = 12'h100,
    S_SP_HIGH = 12'h200,
    S_SP_REL  = 12'h400
  } i2m_state_e;

endpackage : i2m_pkg

/* src/i2m_sync.sv */
/*
  Three-stage synchroniser with agreement filter for one bus line.
  Assumes an idle-high open-drain line sampled on clk.
*/
`timescale 1ns/1ps

module i2m_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Line
  input  wire logic line_i,
  output logic      level_q
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= line_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= 1'b1;
    end else if (s2_ff == s3_ff) begin
      level_q <= s3_ff;
    end
  end

endmodule : i2m_sync

/* bench/i2m_slave_model.sv */
/*
  Behavioural slave, with no address match, on the open-drain SCL/SDA pair.
  Assumes resolved line levels at its inputs; pulls are active high.
*/
`timescale 1ns/1ps

module i2m_slave_model (
  // Lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour select
  input  wire logic       ack_en,
  input  wire logic       stretch,
  // Pulls and captured byte
  output logic            sda_pull = 1'b0,
  output logic            scl_pull = 1'b0,
  output logic      [7:0] rx_byte  = 8'h00
);
  int bits = 0;

  // Start or repeated start restarts the bit count
  always @(negedge sda) if (scl) bits = 0;

  always @(posedge scl) begin
    if (bits < 8) rx_byte = {rx_byte[6:0], sda};
    bits = (bits == 8) ? 0 : bits + 1;
  end

  // Ack driven through the ninth low and high phase; optional stretch
  always @(negedge scl) begin
    sda_pull = (bits == 8) && ack_en;
    if (stretch) begin
      scl_pull = 1'b1;
      #600 scl_pull = 1'b0;
    end
  end
endmodule : i2m_slave_model

/* bench/i2m_master_tb_top.sv */
/*
  Self-checking bench of the I2C master sequencer.
  Assumes the slave model on the lines and the register map of i2m_params.svh.
*/
`timescale 1ns/1ps
`include "i2m_params.svh"

module i2m_master_tb_top;
  logic       clk = 0, rst = 1, wr_en = 0, rd_en = 0;
  logic       tb_low = 0, ack_en = 1, stretch = 0, tb_scl_low = 0, tb_sda_low = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rx_byte, d;
  logic       scl_oe, sda_oe, scl_pull, sda_pull, scl_w, sda_w, scl_od, sda_od;
  int         err_total = 0, checks_done = 0;
  // Byte, slave acks, slave stretches
  logic [9:0] rows [4] = '{{8'hA4, 2'b10}, {8'h5B, 2'b00}, {8'hFF, 2'b11}, {8'h01, 2'b10}};

  always #20 clk = ~clk;
  assign scl_w = ~(scl_oe | scl_pull | tb_low | tb_scl_low);
  assign sda_w = ~(sda_oe | sda_pull | tb_low | tb_sda_low);

  i2m_master dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .scl_i(scl_w), .scl_o(scl_od), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_od), .sda_oe(sda_oe));
  i2m_slave_model slave (.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .stretch(stretch),
    .sda_pull(sda_pull), .scl_pull(scl_pull), .rx_byte(rx_byte));

  // ************************************************************
  // Tasks
  // ************************************************************
  task final_report;
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd

  // Polls one flag bit, then clears the event flag
  task wait_flag(input int b);
    int n;
    n = 0;
    d = 8'h00;
    while (d[b] !== 1'b1) begin
      rd(`I2M_OFS_FLAG);
      n++;
      if (n > 3000) begin
        err_total++;
        final_report;
      end
    end
    wr(`I2M_OFS_FLAG, 8'h01);
  endtask : wait_flag

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    chk({6'h00, scl_od, sda_od}, 8'h00);
    rd(`I2M_OFS_BAUD);
    chk(d, `I2M_BAUD_RST);
    rd(8'h20);
    chk(d, 8'h00);
    wr(`I2M_OFS_BAUD, 8'h03);
    repeat (6) @(posedge clk);
    wr(`I2M_OFS_CTL, 8'h01);
    wr(`I2M_OFS_BUF, 8'h77);
    wr(`I2M_OFS_CTL, 8'h04);
    wait_flag(0);
    rd(`I2M_OFS_CTL);
    chk(d, 8'h00);
    chk({7'h00, sda_oe}, 8'h01);
    rd(`I2M_OFS_STAT);
    chk(d & 8'h02, 8'h02);
    rd(`I2M_OFS_FLAG);
    chk(d, 8'h04);
    wr(`I2M_OFS_FLAG, 8'h04);
    rd(`I2M_OFS_FLAG);
    chk(d, 8'h00);
    rd(`I2M_OFS_BUF);
    chk(d, 8'h00);
    foreach (rows[i]) begin
      ack_en  <= rows[i][1];
      stretch <= rows[i][0];
      wr(`I2M_OFS_BUF, rows[i][9:2]);
      rd(`I2M_OFS_STAT);
      chk(d & 8'h01, 8'h01);
      wr(`I2M_OFS_CTL, 8'h02);
      wait_flag(0);
      chk(rx_byte, rows[i][9:2]);
      rd(`I2M_OFS_CTL);
      chk(d, rows[i][1] ? 8'h00 : 8'h40);
      rd(`I2M_OFS_STAT);
      chk(d & 8'h01, 8'h00);
      chk({7'h00, scl_oe}, 8'h01);
    end
    wr(`I2M_OFS_CTL, 8'h02);
    wait_flag(0);
    rd(`I2M_OFS_CTL);
    chk(d, 8'h00);
    rd(`I2M_OFS_STAT);
    chk(d & 8'h02, 8'h02);
    chk({6'h00, scl_oe, sda_oe}, 8'h03);
    wr(`I2M_OFS_CTL, 8'h04);
    wait_flag(0);
    rd(`I2M_OFS_STAT);
    chk(d & 8'h04, 8'h04);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    tb_low <= 1'b1;
    repeat (6) @(posedge clk);
    wr(`I2M_OFS_CTL, 8'h01);
    wait_flag(1);
    rd(`I2M_OFS_CTL);
    chk(d, 8'h00);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    tb_low <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`I2M_OFS_FLAG);
    chk(d & 8'h02, 8'h02);
    // SCL pulled low by another master while the start waits
    wr(`I2M_OFS_FLAG, 8'h02);
    wr(`I2M_OFS_BAUD, 8'h10);
    wr(`I2M_OFS_CTL, 8'h01);
    tb_scl_low <= 1'b1;
    wait_flag(1);
    rd(`I2M_OFS_STAT);
    chk(d & 8'h02, 8'h00);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    tb_scl_low <= 1'b0;
    // SDA held low by another master through a repeated start
    wr(`I2M_OFS_FLAG, 8'h02);
    tb_sda_low <= 1'b1;
    wr(`I2M_OFS_CTL, 8'h02);
    wait_flag(1);
    rd(`I2M_OFS_CTL);
    chk(d, 8'h00);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    tb_sda_low <= 1'b0;
    final_report;
  end
endmodule : i2m_master_tb_top
